// file: core/stoc_core.v
// Function
// - Timeout fault sets status bits, alerts host
// - Response zero ignores fault, keeps converting
// - Response one waits delay, then shuts down if vout still low
// - Response two shuts down at once
// - Unsupported action byte rejected, flagged, alerted
// - Retry zero latches off after shutdown
// - Retry one to six limits restart attempts
// - Retry seven restarts without limit
// - Delay zero: no wait, hiccup equals rise
// - Delay N: N ms, hiccup N rises
// - Stop waits turn-off delay before ending
// - Turn-off delay zero to 127.5 ms
// - Up to 50 us extra latency added
// - Time words use exponent/mantissa linear coding
// - After delay, reference ramps over fall time
// - Ramp length independent of output voltage
// - Fall word step is quarter millisecond
// - Fall time 0.5 to 31.75 ms
// - Fall below 0.5 ms runs 0.5 ms
// - Out-of-range time words rejected, flagged, alerted
// - Timeout fault if vout below 87.5 percent
// - Zero timeout limit disables detection
`timescale 1ns/100ps
`include "stoc_consts.vh"

module stoc_core #(
  parameter QMS_CYCLES = `STOC_QMS_NS / `STOC_CLK_PERIOD_NS,
  parameter LAT_CYCLES = `STOC_LATENCY_NS / `STOC_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // Command port
  input wire cmd_valid_i,
  input wire cmd_write_i,
  input wire [7:0] cmd_code_i,
  input wire [15:0] cmd_wdata_i,
  output reg [15:0] cmd_rdata_o,
  output reg cmd_ack_o,
  output reg cmd_bad_o,
  // Run request pin and converter inputs
  input wire run_i,
  input wire [7:0] rise_qms_i,
  input wire [7:0] tmax_hms_i,
  input wire [15:0] vout_sample_i,
  input wire [15:0] vout_cmd_i,
  input wire clear_faults_i,
  // Converter control outputs
  output reg converting_o,
  output reg soft_off_o,
  output reg ramp_tick_o,
  output reg [7:0] ramp_len_o,
  output reg latched_off_o,
  // Status outputs
  output reg stat_none_above_o,
  output reg stat_vout_o,
  output reg stat_ton_max_o,
  output reg stat_cml_data_o,
  output reg alert_o
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_OFF = 4'h0;
  localparam S_RISE = 4'h1;
  localparam S_ON = 4'h2;
  localparam S_FDLY = 4'h3;
  localparam S_HIC = 4'h4;
  localparam S_LATCH = 4'h5;
  localparam S_OFFDLY = 4'h6;
  localparam S_OFFLAT = 4'h7;
  localparam S_FALL = 4'h8;

  // ----------------------------------------
  // Linear word to quarter milliseconds
  // ----------------------------------------
  // Returns {exact, value}; exact is low for negatives or lost fraction
  function [12:0] to_qms;
    input [15:0] word;
    integer e;
    integer sh;
    integer m;
    integer v;
    begin
      e = word[`STOC_EXP_MSB:`STOC_EXP_LSB];
      if (e > 15) begin
        e = e - 32;
      end
      m = word[`STOC_MAN_MSB:`STOC_MAN_LSB];
      sh = e + 2;
      to_qms = 13'h0000;
      if (m < 1024) begin
        if (sh >= 0) begin
          if (sh < 12) begin
            v = m * (1 << sh);
            to_qms = (v < 4096) ? {1'b1, v[11:0]} : 13'h0000;
          end else begin
            to_qms = (m == 0) ? 13'h1000 : 13'h0000;
          end
        end else begin
          v = m / (1 << (-sh));
          if (v * (1 << (-sh)) == m) begin
            to_qms = {1'b1, v[11:0]};
          end
        end
      end
    end
  endfunction

  // ----------------------------------------
  // Run pin synchroniser
  // ----------------------------------------
  reg run_meta; // First stage, read only by run_s
  reg run_s; // Synchronised run request
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_meta <= 1'b0;
      run_s <= 1'b0;
    end else begin
      run_meta <= run_i;
      run_s <= run_meta;
    end
  end

  // ----------------------------------------
  // Settings
  // ----------------------------------------
  reg [7:0] action; // Timeout action byte
  reg [15:0] off_wait_word; // Turn-off delay word as written
  reg [15:0] off_ramp_word; // Fall-time word as written
  reg [8:0] off_wait_qms; // Decoded turn-off delay
  reg [6:0] off_ramp_qms; // Decoded fall time
  wire [1:0] timeout_response_code = action[`STOC_RESP_MSB:`STOC_RESP_LSB];
  wire [2:0] timeout_restart_count = action[`STOC_RETRY_MSB:`STOC_RETRY_LSB];
  wire [2:0] timeout_delay_multiplier = action[`STOC_DELAY_MSB:`STOC_DELAY_LSB];
  wire [12:0] wr_qms = to_qms(cmd_wdata_i);
  wire wr_go = cmd_valid_i & cmd_write_i;
  wire act_ok = (cmd_wdata_i[`STOC_RESP_MSB:`STOC_RESP_LSB] != 2'h3);
  wire wait_ok = wr_qms[12] & (wr_qms[11:0] <= `STOC_OFF_WAIT_MAX_QMS);
  // Fall range check, short values kept
  wire ramp_ok = wr_qms[12] & (wr_qms[11:0] <= `STOC_OFF_RAMP_MAX_QMS);
  reg bad_wr; // Rejected write this cycle
  always @* begin
    bad_wr = 1'b0;
    if (wr_go) begin
      case (cmd_code_i)
        `STOC_CMD_ACTION: bad_wr = ~act_ok;
        `STOC_CMD_OFF_WAIT: bad_wr = ~wait_ok;
        `STOC_CMD_OFF_RAMP: bad_wr = ~ramp_ok;
        default: bad_wr = 1'b0;
      endcase
    end
  end

  // Register writes and read answer
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      action <= `STOC_ACTION_RST;
      off_wait_word <= `STOC_OFF_WAIT_RST;
      off_ramp_word <= `STOC_OFF_RAMP_RST;
      off_wait_qms <= 9'h000;
      off_ramp_qms <= 7'h04;
      cmd_rdata_o <= 16'h0000;
      cmd_ack_o <= 1'b0;
      cmd_bad_o <= 1'b0;
    end else begin
      cmd_ack_o <= cmd_valid_i;
      cmd_bad_o <= bad_wr;
      if (wr_go && !bad_wr) begin
        case (cmd_code_i)
          `STOC_CMD_ACTION: action <= cmd_wdata_i[7:0];
          `STOC_CMD_OFF_WAIT: begin
            off_wait_word <= cmd_wdata_i;
            off_wait_qms <= wr_qms[8:0];
          end
          `STOC_CMD_OFF_RAMP: begin
            off_ramp_word <= cmd_wdata_i;
            off_ramp_qms <= wr_qms[6:0];
          end
          default: action <= action;
        endcase
      end
      if (cmd_valid_i && !cmd_write_i) begin
        case (cmd_code_i)
          `STOC_CMD_ACTION: cmd_rdata_o <= {8'h00, action};
          `STOC_CMD_OFF_WAIT: cmd_rdata_o <= off_wait_word;
          `STOC_CMD_OFF_RAMP: cmd_rdata_o <= off_ramp_word;
          default: cmd_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Effective phase lengths
  // ----------------------------------------
  // Rise and fall below 0.5 ms run as 0.5 ms
  wire [7:0] rise_eff = (rise_qms_i < `STOC_RISE_MIN_QMS) ? 8'h02 : rise_qms_i;
  wire [7:0] fall_eff = (off_ramp_qms < `STOC_OFF_RAMP_MIN_QMS) ? 8'h02 : {1'b0, off_ramp_qms};
  wire [2:0] hic_mult = (timeout_delay_multiplier == 3'h0) ? 3'h1 : timeout_delay_multiplier;
  wire [11:0] hic_len = rise_eff * hic_mult;
  wire [11:0] fdly_len = {7'h00, timeout_delay_multiplier, 2'h0};

  wire vout_low = ({vout_sample_i, 3'h0} < (vout_cmd_i * 19'd7));

  // ----------------------------------------
  // Phase and timeout timers
  // ----------------------------------------
  reg [3:0] state; // Sequencer state
  reg [3:0] next_state;
  reg [11:0] next_len;
  reg [15:0] pre_ph; // Cycle prescaler, restarts per phase
  reg [11:0] ph_cnt; // Quarter ms ticks in phase
  reg [11:0] ph_len; // Phase length latched at entry
  reg [15:0] pre_tm; // Timeout prescaler
  reg [8:0] tm_cnt; // Timeout ticks elapsed
  reg [8:0] tm_tgt; // Timeout target latched at rise start
  reg tm_run; // Timeout timer armed
  reg [2:0] attempts; // Restart attempts used
  wire tick_ph = (pre_ph == QMS_CYCLES - 1);
  wire tick_tm = (pre_tm == QMS_CYCLES - 1);
  wire ph_done = (ph_cnt >= ph_len);
  wire tm_hit = tm_run & tick_tm & (tm_cnt == tm_tgt - 9'h001);
  wire fault_ev = tm_hit & vout_low & ((state == S_RISE) || (state == S_ON));
  wire start_ok = tm_hit & ~vout_low;
  // Restart allowed while attempts remain
  wire may_retry = (timeout_restart_count == `STOC_RETRY_FOREVER) ||
                   (attempts < timeout_restart_count);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    next_state = state;
    next_len = ph_len;
    case (state)
      S_OFF: begin
        if (run_s) begin
          next_state = S_RISE;
          next_len = {4'h0, rise_eff};
        end
      end
      S_RISE, S_ON: begin
        if (!run_s) begin
          next_state = S_OFFDLY;
          next_len = {3'h0, off_wait_qms};
        end else if (fault_ev) begin
          case (timeout_response_code)
            `STOC_RESP_DELAYED: begin
              next_state = S_FDLY;
              next_len = fdly_len;
            end
            `STOC_RESP_IMMEDIATE: begin
              next_state = S_OFF;
            end
            default: begin
              next_state = state;
            end
          endcase
        end else if ((state == S_RISE) && ph_done) begin
          next_state = S_ON;
        end
      end
      S_FDLY: begin
        if (!run_s) begin
          next_state = S_OFFDLY;
          next_len = {3'h0, off_wait_qms};
        end else if (ph_done) begin
          // Shut down only if still low
          next_state = vout_low ? S_OFF : S_ON;
        end
      end
      S_HIC: begin
        if (!run_s) begin
          next_state = S_OFF;
        end else if (ph_done) begin
          next_state = S_RISE;
          next_len = {4'h0, rise_eff};
        end
      end
      S_LATCH: begin
        // Latch released only by removing run
        if (!run_s) begin
          next_state = S_OFF;
        end
      end
      S_OFFDLY: begin
        if (ph_done) begin
          next_state = S_OFFLAT;
        end
      end
      S_OFFLAT: begin
        if (pre_ph == LAT_CYCLES - 1) begin
          next_state = S_FALL;
          next_len = {4'h0, fall_eff};
        end
      end
      S_FALL: begin
        if (ph_done) begin
          next_state = S_OFF;
        end
      end
      default: begin
        next_state = S_OFF;
      end
    endcase
    // Shutdown from a fault goes on to retry policy; the end of a
    // soft-off ramp with run back high must restart, not latch
    if (((state == S_RISE) || (state == S_ON) || (state == S_FDLY)) &&
        (next_state == S_OFF) && run_s) begin
      if ((timeout_restart_count == `STOC_RETRY_NONE) || !may_retry) begin
        next_state = S_LATCH;
      end else begin
        next_state = S_HIC;
        next_len = hic_len;
      end
    end
  end

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= S_OFF;
      pre_ph <= 16'h0000;
      ph_cnt <= 12'h000;
      ph_len <= 12'h000;
      pre_tm <= 16'h0000;
      tm_cnt <= 9'h000;
      tm_tgt <= 9'h000;
      tm_run <= 1'b0;
      attempts <= 3'h0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        pre_ph <= 16'h0000;
        ph_cnt <= 12'h000;
        ph_len <= next_len;
      end else begin
        pre_ph <= tick_ph ? 16'h0000 : pre_ph + 16'h0001;
        if (tick_ph && !ph_done) begin
          ph_cnt <= ph_cnt + 12'h001;
        end
      end
      if ((next_state == S_RISE) && (state != S_RISE)) begin
        tm_run <= (tmax_hms_i != 8'h00);
        tm_tgt <= {tmax_hms_i, 1'b0};
        pre_tm <= 16'h0000;
        tm_cnt <= 9'h000;
      end else if (tm_run) begin
        pre_tm <= tick_tm ? 16'h0000 : pre_tm + 16'h0001;
        if (tick_tm) begin
          tm_cnt <= tm_cnt + 9'h001;
        end
        if (tm_hit || !((state == S_RISE) || (state == S_ON))) begin
          tm_run <= 1'b0;
        end
      end
      if (!run_s || start_ok || ((state == S_RISE) && ph_done && !tm_run)) begin
        attempts <= 3'h0;
      end else if ((state == S_HIC) && (next_state == S_RISE) && (attempts != 3'h7)) begin
        attempts <= attempts + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Outputs and status
  // ----------------------------------------
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      converting_o <= 1'b0;
      soft_off_o <= 1'b0;
      ramp_tick_o <= 1'b0;
      ramp_len_o <= 8'h00;
      latched_off_o <= 1'b0;
      stat_none_above_o <= 1'b0;
      stat_vout_o <= 1'b0;
      stat_ton_max_o <= 1'b0;
      stat_cml_data_o <= 1'b0;
      alert_o <= 1'b0;
    end else begin
      converting_o <= (next_state != S_OFF) && (next_state != S_HIC) &&
                      (next_state != S_LATCH);
      soft_off_o <= (next_state == S_FALL);
      // One ramp step per quarter ms
      ramp_tick_o <= (state == S_FALL) && tick_ph && !ph_done;
      if ((next_state == S_FALL) && (state != S_FALL)) begin
        ramp_len_o <= next_len[7:0];
      end
      latched_off_o <= (next_state == S_LATCH);
      // Status bits, set wins over clear
      if (fault_ev) begin
        stat_none_above_o <= 1'b1;
        stat_vout_o <= 1'b1;
        stat_ton_max_o <= 1'b1;
      end else if (clear_faults_i) begin
        stat_none_above_o <= 1'b0;
        stat_vout_o <= 1'b0;
        stat_ton_max_o <= 1'b0;
      end
      if (bad_wr) begin
        stat_cml_data_o <= 1'b1;
      end else if (clear_faults_i) begin
        stat_cml_data_o <= 1'b0;
      end
      if (fault_ev || bad_wr) begin
        alert_o <= 1'b1;
      end else if (clear_faults_i) begin
        alert_o <= 1'b0;
      end
    end
  end

endmodule // stoc_core

// file: common/stoc_consts.vh
`ifndef STOC_CONSTS_VH
`define STOC_CONSTS_VH
// ----------------------------------------
// Command codes of the three settings
// ----------------------------------------
`define STOC_CMD_ACTION 8'h63
`define STOC_CMD_OFF_WAIT 8'h64
`define STOC_CMD_OFF_RAMP 8'h65
// ----------------------------------------
// Field positions
// ----------------------------------------
`define STOC_RESP_MSB 7
`define STOC_RESP_LSB 6
`define STOC_RETRY_MSB 5
`define STOC_RETRY_LSB 3
`define STOC_DELAY_MSB 2
`define STOC_DELAY_LSB 0
`define STOC_EXP_MSB 15
`define STOC_EXP_LSB 11
`define STOC_MAN_MSB 10
`define STOC_MAN_LSB 0
// ----------------------------------------
// Response and retry encodings
// ----------------------------------------
`define STOC_RESP_IGNORE 2'h0
`define STOC_RESP_DELAYED 2'h1
`define STOC_RESP_IMMEDIATE 2'h2
`define STOC_RETRY_NONE 3'h0
`define STOC_RETRY_FOREVER 3'h7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define STOC_ACTION_RST 8'h80
`define STOC_OFF_WAIT_RST 16'hf800
`define STOC_OFF_RAMP_RST 16'hf004
// ----------------------------------------
// Limits in quarter milliseconds
// ----------------------------------------
`define STOC_OFF_WAIT_MAX_QMS 510
`define STOC_OFF_RAMP_MAX_QMS 127
`define STOC_OFF_RAMP_MIN_QMS 2
`define STOC_RISE_MIN_QMS 2
`define STOC_QMS_PER_MS 4
// ----------------------------------------
// Timing
// ----------------------------------------
`define STOC_CLK_PERIOD_NS 100
`define STOC_QMS_NS 250000
`define STOC_LATENCY_NS 50000
`endif

// file: test/stoc_core_asserts.sv
`timescale 1ns/100ps
module stoc_core_asserts #(
  parameter QMS_CYCLES = 2500,
  parameter LAT_CYCLES = 500
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // Command port
  input wire cmd_valid_i,
  input wire cmd_write_i,
  input wire [7:0] cmd_code_i,
  input wire [15:0] cmd_wdata_i,
  input wire [15:0] cmd_rdata_o,
  input wire cmd_ack_o,
  input wire cmd_bad_o,
  // Converter control
  input wire converting_o,
  input wire soft_off_o,
  input wire ramp_tick_o,
  input wire [7:0] ramp_len_o,
  input wire latched_off_o,
  // Status
  input wire stat_none_above_o,
  input wire stat_vout_o,
  input wire stat_ton_max_o,
  input wire stat_cml_data_o,
  input wire alert_o
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  reg [7:0] tick_cnt; // Ticks seen in the current fall ramp
  wire wr_go = cmd_valid_i && cmd_write_i; // Write taken this edge
  // Count ramp ticks, cleared outside the ramp
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt <= 8'h00;
    end else if (!soft_off_o) begin
      tick_cnt <= 8'h00;
    end else if (ramp_tick_o) begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_bad_action;
    wr_go && cmd_code_i == 8'h63 && cmd_wdata_i[7:6] == 2'h3
      |=> cmd_bad_o && stat_cml_data_o && alert_o;
  endproperty
  a_bad_action: assert property (p_bad_action) else $error("bad action not refused");
  property p_good_action;
    wr_go && cmd_code_i == 8'h63 && cmd_wdata_i[7:6] != 2'h3 |=> cmd_ack_o && !cmd_bad_o;
  endproperty
  a_good_action: assert property (p_good_action) else $error("good action refused");
  property p_wait_range;
    wr_go && cmd_code_i == 8'h64 && cmd_wdata_i[15:11] == 5'h1e && cmd_wdata_i[10:0] > 11'h1fe
      |=> cmd_bad_o;
  endproperty
  a_wait_range: assert property (p_wait_range) else $error("long wait accepted");
  property p_ramp_range;
    wr_go && cmd_code_i == 8'h65 && cmd_wdata_i[15:11] == 5'h1e && !cmd_wdata_i[10]
      && cmd_wdata_i[9:0] > 10'h07f |=> cmd_bad_o && alert_o;
  endproperty
  a_ramp_range: assert property (p_ramp_range) else $error("long ramp accepted");
  property p_ramp_short;
    wr_go && cmd_code_i == 8'h65 && cmd_wdata_i == 16'hf001 |=> cmd_ack_o && !cmd_bad_o;
  endproperty
  a_ramp_short: assert property (p_ramp_short) else $error("short ramp refused");
  property p_fault_status;
    $rose(stat_ton_max_o) |-> stat_vout_o && stat_none_above_o && alert_o;
  endproperty
  a_fault_status: assert property (p_fault_status) else $error("fault flags incomplete");
  property p_tick_in_fall;
    ramp_tick_o |-> soft_off_o && converting_o && ramp_len_o >= 8'h02;
  endproperty
  a_tick_in_fall: assert property (p_tick_in_fall) else $error("tick outside ramp");
  property p_ramp_held;
    soft_off_o && $past(soft_off_o) |-> $stable(ramp_len_o);
  endproperty
  a_ramp_held: assert property (p_ramp_held) else $error("ramp length moved");
  property p_tick_total;
    $fell(soft_off_o) |-> tick_cnt == ramp_len_o;
  endproperty
  a_tick_total: assert property (p_tick_total) else $error("ramp tick count wrong");
  property p_latched_dark;
    latched_off_o |-> !converting_o && !soft_off_o;
  endproperty
  a_latched_dark: assert property (p_latched_dark) else $error("latched but converting");
  property p_unmapped;
    cmd_valid_i && !cmd_write_i && (cmd_code_i < 8'h63 || cmd_code_i > 8'h65)
      |=> cmd_ack_o && cmd_rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // stoc_core_asserts

bind stoc_core stoc_core_asserts #(.QMS_CYCLES(QMS_CYCLES), .LAT_CYCLES(LAT_CYCLES))
  u_stoc_core_asserts (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
  .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
  .cmd_rdata_o(cmd_rdata_o), .cmd_ack_o(cmd_ack_o), .cmd_bad_o(cmd_bad_o),
  .converting_o(converting_o), .soft_off_o(soft_off_o), .ramp_tick_o(ramp_tick_o),
  .ramp_len_o(ramp_len_o), .latched_off_o(latched_off_o),
  .stat_none_above_o(stat_none_above_o), .stat_vout_o(stat_vout_o),
  .stat_ton_max_o(stat_ton_max_o), .stat_cml_data_o(stat_cml_data_o), .alert_o(alert_o));

// file: test/stoc_host.sv
`timescale 1ns/100ps
module stoc_host (
  // Clock
  input wire clk_i,
  // Request
  output reg cmd_valid_o,
  output reg cmd_write_o,
  output reg [7:0] cmd_code_o,
  output reg [15:0] cmd_wdata_o,
  // Answer
  input wire [15:0] cmd_rdata_i,
  input wire cmd_ack_i,
  input wire cmd_bad_i
);
  // Idle request lines at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 16'h0000;
  end
  // One command, answer taken one edge after the request
  task xfer(input w, input [7:0] c, input [15:0] d, output [15:0] r, output a, output b);
    begin
      @(posedge clk_i);
      #1;
      cmd_valid_o = 1'b1;
      cmd_write_o = w;
      cmd_code_o = c;
      cmd_wdata_o = d;
      @(posedge clk_i);
      #1;
      r = cmd_rdata_i;
      a = cmd_ack_i;
      b = cmd_bad_i;
      // Released lines show the inverse, never the last value
      cmd_valid_o = 1'b0;
      cmd_write_o = ~w;
      cmd_code_o = ~c;
      cmd_wdata_o = ~d;
    end
  endtask
endmodule // stoc_host

// file: test/stoc_core_test.sv
`timescale 1ns/100ps
`include "stoc_consts.vh"
`define TB_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error at %0t: got %h exp %h", $time, (g), (e)); end end
module stoc_core_test;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  reg clk_i, reset_n_i, run_i, clear_faults_i;
  reg [7:0] rise_qms_i, tmax_hms_i;
  reg [15:0] vout_sample_i, vout_cmd_i, rd, rv;
  reg ack, bad;
  wire cmd_valid_i, cmd_write_i, cmd_ack_o, cmd_bad_o, converting_o, soft_off_o, ramp_tick_o;
  wire latched_off_o, stat_none_above_o, stat_vout_o, stat_ton_max_o, stat_cml_data_o, alert_o;
  wire [7:0] cmd_code_i, ramp_len_o;
  wire [15:0] cmd_wdata_i, cmd_rdata_o;
  reg [15:0] mdl [0:2]; // Expected register contents
  integer error_cnt = 0, n_compared = 0, seed = 58, i;
  stoc_core #(.QMS_CYCLES(4), .LAT_CYCLES(3)) u_stoc_core (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
    .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o),
    .cmd_ack_o(cmd_ack_o), .cmd_bad_o(cmd_bad_o), .run_i(run_i), .rise_qms_i(rise_qms_i),
    .tmax_hms_i(tmax_hms_i), .vout_sample_i(vout_sample_i), .vout_cmd_i(vout_cmd_i),
    .clear_faults_i(clear_faults_i), .converting_o(converting_o), .soft_off_o(soft_off_o),
    .ramp_tick_o(ramp_tick_o), .ramp_len_o(ramp_len_o), .latched_off_o(latched_off_o),
    .stat_none_above_o(stat_none_above_o), .stat_vout_o(stat_vout_o),
    .stat_ton_max_o(stat_ton_max_o), .stat_cml_data_o(stat_cml_data_o), .alert_o(alert_o));
  stoc_host u_stoc_host (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
    .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i), .cmd_rdata_i(cmd_rdata_o),
    .cmd_ack_i(cmd_ack_o), .cmd_bad_i(cmd_bad_o));
  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task clk_n(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  // Refusal worked out from the field layouts, quarters of a ms
  function integer bad_of(input [7:0] c, input [15:0] d);
    integer e, m, q;
    begin
      e = $signed(d[15:11]);
      m = $signed(d[10:0]);
      q = 0;
      if (e >= -2) q = m * (1 << (e + 2));
      else if (m % (1 << (-2 - e)) != 0) q = 9999;
      else q = m / (1 << (-2 - e));
      if (c == 8'h63) bad_of = (d[7:6] == 2'h3);
      else bad_of = (m < 0) || (q > ((c == 8'h64) ? 510 : 127));
    end
  endfunction
  task rd_chk(input [7:0] c, input [15:0] e);
    begin
      u_stoc_host.xfer(1'b0, c, 16'h0000, rd, ack, bad);
      `TB_CHK(rd, e)
    end
  endtask
  task regs_chk;
    begin
      mdl[0] = {8'h00, `STOC_ACTION_RST};
      mdl[1] = `STOC_OFF_WAIT_RST;
      mdl[2] = `STOC_OFF_RAMP_RST;
      for (i = 0; i < 3; i++) rd_chk(8'h63 + i[7:0], mdl[i]);
    end
  endtask
  task wr_chk(input [7:0] c, input [15:0] d);
    integer eb;
    begin
      eb = bad_of(c, d);
      u_stoc_host.xfer(1'b1, c, d, rd, ack, bad);
      `TB_CHK(ack, 1'b1)
      `TB_CHK(bad, eb[0])
      if (eb == 0) mdl[c - 8'h63] = (c == 8'h63) ? {8'h00, d[7:0]} : d;
      else `TB_CHK(alert_o & stat_cml_data_o, 1'b1)
      rd_chk(c, mdl[c - 8'h63]);
    end
  endtask
  // Stop while running; wait ticks wt, ramp ticks expected fl
  task stop_run(input [15:0] ww, input [15:0] fw, input integer wt, input integer fl);
    integer cyc, k, lo;
    reg [7:0] rl;
    begin
      wr_chk(8'h64, ww);
      wr_chk(8'h65, fw);
      tmax_hms_i = 8'h00;
      run_i = 1'b1;
      clk_n(30);
      `TB_CHK(converting_o, 1'b1)
      run_i = 1'b0;
      lo = wt * 4 + 3;
      for (cyc = 0; cyc < 300 && soft_off_o !== 1'b1; cyc++) clk_n(1);
      if (cyc == 300) begin
        error_cnt++;
        tally_and_finish;
      end
      `TB_CHK((cyc >= lo) && (cyc <= lo + 6), 1'b1)
      k = 0;
      rl = 8'h00;
      for (cyc = 0; cyc < 300 && soft_off_o === 1'b1; cyc++) begin
        if (ramp_tick_o === 1'b1) begin
          k++;
          rl = ramp_len_o;
        end
        clk_n(1);
      end
      if (cyc == 300) begin
        error_cnt++;
        tally_and_finish;
      end
      `TB_CHK(k, fl)
      `TB_CHK(rl, fl[7:0])
      clk_n(3);
      `TB_CHK(converting_o, 1'b0)
    end
  endtask
  // Start-up with a low or good output; counts starts over 400 cycles
  task fault_run(input [7:0] act, input integer vs, input integer tm);
    integer flt, rt, lat, rises;
    reg prev;
    begin
      wr_chk(8'h63, {8'h00, act});
      vout_sample_i = vs[15:0];
      tmax_hms_i = tm[7:0];
      clear_faults_i = 1'b1;
      clk_n(1);
      clear_faults_i = 1'b0;
      run_i = 1'b1;
      rises = 0;
      prev = 1'b0;
      repeat (400) begin
        clk_n(1);
        if (converting_o === 1'b1 && !prev) rises++;
        prev = converting_o;
      end
      flt = (tm != 0) && (8 * vs < 700);
      rt = act[5:3];
      lat = flt && act[7:6] != 2'h0 && rt != 7;
      `TB_CHK(stat_ton_max_o, flt[0])
      `TB_CHK(stat_vout_o & stat_none_above_o & alert_o, flt[0])
      `TB_CHK(latched_off_o, lat[0])
      if (flt && act[7:6] != 2'h0 && rt == 7) `TB_CHK(rises > 8, 1'b1)
      else `TB_CHK(rises, (flt && act[7:6] != 2'h0) ? rt + 1 : 1)
      run_i = 1'b0;
      clk_n(100);
      `TB_CHK(converting_o | latched_off_o, 1'b0)
    end
  endtask
  task tally_and_finish;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n_i = 1'b0;
    run_i = 1'b0;
    clear_faults_i = 1'b0;
    rise_qms_i = 8'h02;
    tmax_hms_i = 8'h02;
    vout_sample_i = 16'h0000;
    vout_cmd_i = 16'd100;
    repeat (3) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    regs_chk;
    rd_chk(8'h66, 16'h0000);
    // Boundaries of each word, plus lost fraction and negative mantissa
    wr_chk(8'h63, 16'h00c0);
    wr_chk(8'h64, 16'hf1ff);
    wr_chk(8'h64, 16'hf1fe);
    wr_chk(8'h64, 16'he801);
    wr_chk(8'h64, 16'hf7ff);
    wr_chk(8'h65, 16'hf080);
    wr_chk(8'h65, 16'hf07f);
    wr_chk(8'h65, 16'hf001);
    for (i = 0; i < 6; i++) begin
      rv = 16'($random(seed));
      wr_chk(8'h63, {8'h00, rv[15:8]});
      wr_chk(8'h64, {7'h78, rv[8:0]});
      wr_chk(8'h65, {8'hf0, rv[7:0]});
    end
    $display("Test registers done");
    stop_run(16'hf800, 16'hf001, 0, 2);
    vout_cmd_i = 16'h4000;
    stop_run(16'hf803, 16'hf005, 6, 5);
    vout_cmd_i = 16'd100;
    $display("Test soft off done");
    fault_run(8'h80, 88, 2);
    fault_run(8'h80, 87, 2);
    fault_run(8'h80, 0, 0);
    fault_run(8'h00, 0, 2);
    fault_run(8'h41, 0, 2);
    fault_run(8'h90, 0, 2);
    fault_run(8'h52, 0, 2);
    fault_run(8'hb0, 0, 2);
    fault_run(8'hb8, 0, 2);
    $display("Test start-up timeout done");
    reset_n_i = 1'b0;
    clk_n(2);
    reset_n_i = 1'b1;
    regs_chk;
    $display("Test second reset done");
    tally_and_finish;
  end
endmodule // stoc_core_test
